// [kds_defines.svh]
// Notes on behaviour
// - Key byte: control, shift, row, column.
// - Sensor mode copies return lines per row.
// - Sensor mode ignores shift and control.
// - Strobe rising edge pushes return lines.
// - Left entry: address 0 leftmost.
// - Left entry wraps back to leftmost.
// - Right entry shifts left, fills rightmost.
// - Right entry drops leftmost character.
// - Auto increment advances write address.
// - No auto increment: same address.
// - Eight characters scan twice as fast.
// - Status shows FIFO count and errors.
// - Push into full FIFO flags overrun.
// - Read of empty FIFO flags underrun.
// - Busy bit while clear runs.
// - Sensor change sets status bit.
// - Special error mode shows multi-key error.
// - 10 us cycle, 80 us rows, debounce.
// - Digit 480 us on, 160 us blank.
// - Status readable at status address.
// - Clear takes one scan, blocks data writes.
// - Full FIFO drops key, sets overrun.
// - Data writes go to display address.
`ifndef KDS_DEFINES_SVH
`define KDS_DEFINES_SVH

// Timing
`define KDS_CLK_MHZ 100
`define KDS_ICYC_US 10
`define KDS_ICYC_CLKS (`KDS_ICYC_US * `KDS_CLK_MHZ)
`define KDS_ROW_US 80
`define KDS_ROW_TICKS (`KDS_ROW_US / `KDS_ICYC_US)
`define KDS_DEBOUNCE_US 10300
`define KDS_DEBOUNCE_TICKS (`KDS_DEBOUNCE_US / `KDS_ICYC_US)
`define KDS_DIGON_US 480
`define KDS_BLANK_US 160
`define KDS_DIGIT_TICKS ((`KDS_DIGON_US + `KDS_BLANK_US) / `KDS_ICYC_US)
`define KDS_BLANK_TICKS (`KDS_BLANK_US / `KDS_ICYC_US)

// Register offsets
`define KDS_OFS_CTRL 4'h0
`define KDS_OFS_CMD 4'h1
`define KDS_OFS_DADDR 4'h2
`define KDS_OFS_DDATA 4'h3
`define KDS_OFS_FIFO 4'h4
`define KDS_OFS_STATUS 4'h5
`define KDS_SENSOR_SEL 3

// Control fields
`define KDS_CTRL_MODE 0
`define KDS_CTRL_DISP8 2
`define KDS_CTRL_RIGHT 3
`define KDS_CTRL_SPECERR 4
`define KDS_CTRL_RESET 8'h00

// Command and address fields
`define KDS_CMD_CLR_DISP 0
`define KDS_CMD_CLR_FIFO 1
`define KDS_CMD_CLR_ALL 2
`define KDS_DADDR_AI 4
`define KDS_CLEAR_CODE 8'h00

// FIFO and status layout
`define KDS_FIFO_DEPTH 8
`define KDS_ST_BUSY 7
`define KDS_ST_SE 6
`define KDS_ST_UNDER 5
`define KDS_ST_OVER 4
`define KDS_ST_FULL 3

`endif

// [kds_dram.sv]
`timescale 1ns/1ps
`default_nettype none
module kds_dram (
	input wire logic clk_i,
	input wire logic ce_i,
	kds_dram_if.mem dram
);
	logic [7:0] mem_r [16];

	// One write port, registered read for the scan
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (dram.we) begin
				mem_r[dram.waddr] <= dram.wdata;
			end
			dram.rdata <= mem_r[dram.raddr];
		end
	end
endmodule // kds_dram
`default_nettype wire

// [kds_dram_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface kds_dram_if;
	logic we;
	logic [3:0] waddr;
	logic [7:0] wdata;
	logic [3:0] raddr;
	logic [7:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// [kds_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module kds_far_model (
	input wire logic clk_i,
	input wire logic [2:0] scan_i,
	output logic [7:0] ret_o,
	output logic shift_o,
	output logic ctrl_stb_o
);
	logic [7:0] keys [8];
	logic strobed;
	logic [7:0] sret;
	initial begin
		strobed = 1'b0;
		sret = 8'h00;
		shift_o = 1'b0;
		ctrl_stb_o = 1'b0;
		foreach (keys[i])
			keys[i] = 8'h00;
	end
	// Matrix answers the scanned row; a strobe source drives its own byte
	assign ret_o = strobed ? sret : keys[scan_i];
	// Data first, then a clean strobe pulse; data is spoiled afterwards
	task automatic pulse(input logic [7:0] d);
		strobed <= 1'b1;
		@(posedge clk_i);
		sret <= d;
		repeat (2) @(posedge clk_i);
		ctrl_stb_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		ctrl_stb_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		sret <= ~d;
	endtask
endmodule // kds_far_model
`default_nettype wire

// [kds_pkg.sv]
`default_nettype none
package kds_pkg;
	typedef enum logic [1:0] {KDS_KEY2, KDS_KEYN, KDS_SENSOR, KDS_STROBE} kds_mode_t;
	typedef enum logic [1:0] {KDS_IDLE, KDS_DEBOUNCE, KDS_HELD} kds_kst_t;
endpackage
`default_nettype wire

// [kds_top.sv]
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "kds_defines.svh"
module kds_top (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic CE_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	input wire logic [7:0] RET_I,
	input wire logic SHIFT_I,
	input wire logic CTRL_STB_I,
	output logic [2:0] SCAN_O,
	output logic [3:0] DIGIT_O,
	output logic [7:0] DISP_DATA_O,
	output logic DISP_BLANK_O
);
	import kds_pkg::*;

	kds_dram_if dram();

	logic [7:0] ctrl_r;
	logic [3:0] daddr_r;
	logic ai_r;
	logic [3:0] base_r;
	logic [9:0] icyc_r;
	logic [2:0] rowt_r;
	logic [2:0] row_r;
	logic [5:0] digt_r;
	logic [3:0] digit_r;
	logic clr_busy_r;
	logic [3:0] clr_ptr_r;
	logic [7:0] ret_m;
	logic [7:0] ret_s;
	logic shift_m;
	logic shift_s;
	logic cstb_m;
	logic cstb_s;
	logic cstb_d;
	kds_kst_t kst_r;
	logic [2:0] key_row_r;
	logic [2:0] key_col_r;
	logic [10:0] deb_r;
	logic err_r;
	logic overrun_r;
	logic underrun_r;
	logic sen_chg_r;
	logic [7:0] fifo_mem [`KDS_FIFO_DEPTH];
	logic [2:0] wptr_r;
	logic [2:0] rptr_r;
	logic [3:0] cnt_r;
	logic [7:0] sensor_ram [8];

	kds_mode_t mode;
	logic disp8;
	logic right;
	logic spec;
	logic [3:0] nmask;
	logic kbd;
	logic tick;
	logic row_end;
	logic dig_end;
	logic wr_ctrl;
	logic wr_cmd;
	logic wr_daddr;
	logic wr_ddata;
	logic rd_fifo;
	logic host_wr;
	logic clr_disp;
	logic clr_fifo;
	logic clr_all;
	logic stb_rise;
	logic other_key;
	logic key_ready;
	logic multi_set;
	logic push_req;
	logic push_ok;
	logic pop_ok;
	logic full;
	logic empty;
	logic [7:0] push_data;
	logic [7:0] status;

	kds_dram u_dram (
		.clk_i(CLK_I),
		.ce_i(CE_I),
		.dram(dram)
	);

	// Lowest closed return line wins
	function automatic logic [2:0] first_col(input logic [7:0] v);
		first_col = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				first_col = 3'(i);
			end
		end
	endfunction

	// Mode fields
	assign mode = kds_mode_t'(ctrl_r[`KDS_CTRL_MODE +: 2]);
	assign disp8 = ctrl_r[`KDS_CTRL_DISP8];
	assign right = ctrl_r[`KDS_CTRL_RIGHT];
	assign spec = ctrl_r[`KDS_CTRL_SPECERR];
	assign nmask = disp8 ? 4'h7 : 4'hf;
	assign kbd = (mode == KDS_KEY2) || (mode == KDS_KEYN);

	// Register write and FIFO read decode
	always_comb begin
		wr_ctrl = 1'b0;
		wr_cmd = 1'b0;
		wr_daddr = 1'b0;
		wr_ddata = 1'b0;
		rd_fifo = 1'b0;
		if (WR_I && ADDR_I == `KDS_OFS_CTRL) begin
			wr_ctrl = 1'b1;
		end else if (WR_I && ADDR_I == `KDS_OFS_CMD) begin
			wr_cmd = 1'b1;
		end else if (WR_I && ADDR_I == `KDS_OFS_DADDR) begin
			wr_daddr = 1'b1;
		end else if (WR_I && ADDR_I == `KDS_OFS_DDATA) begin
			wr_ddata = 1'b1;
		end else if (RD_I && ADDR_I == `KDS_OFS_FIFO) begin
			rd_fifo = 1'b1;
		end
	end

	assign clr_all = wr_cmd && WDATA_I[`KDS_CMD_CLR_ALL];
	assign clr_disp = wr_cmd && WDATA_I[`KDS_CMD_CLR_DISP] || clr_all;
	assign clr_fifo = wr_cmd && WDATA_I[`KDS_CMD_CLR_FIFO] || clr_all;
	assign host_wr = wr_ddata && !clr_busy_r;

	// Control register
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ctrl_r <= `KDS_CTRL_RESET;
		end else if (CE_I && wr_ctrl) begin
			ctrl_r <= WDATA_I;
		end
	end

	// Internal cycle divider; clear all restarts the chain
	assign tick = icyc_r == 10'(`KDS_ICYC_CLKS - 1);
	assign row_end = tick && rowt_r == 3'(`KDS_ROW_TICKS - 1);
	assign dig_end = tick && digt_r == 6'(`KDS_DIGIT_TICKS - 1);
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			icyc_r <= 10'h000;
			rowt_r <= 3'h0;
			row_r <= 3'h0;
			digt_r <= 6'h00;
			digit_r <= 4'h0;
		end else if (CE_I) begin
			if (clr_all) begin
				icyc_r <= 10'h000;
				rowt_r <= 3'h0;
				row_r <= 3'h0;
				digt_r <= 6'h00;
				digit_r <= 4'h0;
			end else begin
				icyc_r <= tick ? 10'h000 : icyc_r + 10'h001;
				if (tick) begin
					rowt_r <= rowt_r + 3'h1;
					digt_r <= dig_end ? 6'h00 : digt_r + 6'h01;
				end
				if (row_end) begin
					row_r <= row_r + 3'h1;
				end
				if (dig_end) begin
					digit_r <= (digit_r + 4'h1) & nmask;
				end
			end
		end
	end

	// Pin synchronisers; the edge detector looks only at later stages
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ret_m <= 8'h00;
			ret_s <= 8'h00;
			shift_m <= 1'b0;
			shift_s <= 1'b0;
			cstb_m <= 1'b0;
			cstb_s <= 1'b0;
			cstb_d <= 1'b0;
		end else if (CE_I) begin
			ret_m <= RET_I;
			ret_s <= ret_m;
			shift_m <= SHIFT_I;
			shift_s <= shift_m;
			cstb_m <= CTRL_STB_I;
			cstb_s <= cstb_m;
			cstb_d <= cstb_s;
		end
	end
	assign stb_rise = cstb_s && !cstb_d;

	// Clear sweep: one address per digit period, one full scan
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			clr_busy_r <= 1'b0;
			clr_ptr_r <= 4'h0;
		end else if (CE_I) begin
			if (clr_disp) begin
				clr_busy_r <= 1'b1;
				clr_ptr_r <= 4'h0;
			end else if (clr_busy_r && dig_end) begin
				clr_ptr_r <= clr_ptr_r + 4'h1;
				if (clr_ptr_r == nmask) begin
					clr_busy_r <= 1'b0;
				end
			end
		end
	end

	// Display address, auto increment and right entry base
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			daddr_r <= 4'h0;
			ai_r <= 1'b0;
			base_r <= 4'h0;
		end else if (CE_I) begin
			if (wr_daddr) begin
				daddr_r <= WDATA_I[3:0];
				ai_r <= WDATA_I[`KDS_DADDR_AI];
			end else if (host_wr && ai_r) begin
				daddr_r <= (daddr_r + 4'h1) & nmask;
			end
			if (clr_disp) begin
				base_r <= 4'h0;
			end else if (host_wr) begin
				base_r <= (daddr_r + 4'h1) & nmask;
			end
		end
	end

	// Write port: clear sweep has the port while busy
	assign dram.we = clr_busy_r ? dig_end : host_wr;
	assign dram.waddr = clr_busy_r ? clr_ptr_r : daddr_r;
	assign dram.wdata = clr_busy_r ? `KDS_CLEAR_CODE : WDATA_I;
	// Right entry rotates so the newest character sits rightmost
	assign dram.raddr = right ? ((digit_r + base_r) & nmask) : digit_r;

	// Display pins; blanking at digit start hides the read latency
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			DIGIT_O <= 4'h0;
			DISP_DATA_O <= 8'h00;
			DISP_BLANK_O <= 1'b1;
			SCAN_O <= 3'h0;
		end else if (CE_I) begin
			DIGIT_O <= digit_r;
			DISP_DATA_O <= dram.rdata;
			DISP_BLANK_O <= digt_r < 6'(`KDS_BLANK_TICKS) || clr_busy_r;
			SCAN_O <= row_r;
		end
	end

	// Key detection helpers
	assign other_key = (row_r != key_row_r) ? |ret_s : |(ret_s & ~(8'h01 << key_col_r));
	assign key_ready = kbd && row_end && kst_r == KDS_DEBOUNCE && row_r == key_row_r
		&& deb_r == 11'h000 && ret_s[key_col_r];
	assign multi_set = mode == KDS_KEYN && spec && row_end && kst_r == KDS_DEBOUNCE && other_key;

	// Key state machine, evaluated once per scanned row
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			kst_r <= KDS_IDLE;
			key_row_r <= 3'h0;
			key_col_r <= 3'h0;
		end else if (CE_I) begin
			if (!kbd || clr_all) begin
				kst_r <= KDS_IDLE;
			end else if (row_end) begin
				case (kst_r)
					KDS_IDLE: begin
						if (|ret_s) begin
							key_row_r <= row_r;
							key_col_r <= first_col(ret_s);
							kst_r <= KDS_DEBOUNCE;
						end
					end
					KDS_DEBOUNCE: begin
						if (mode == KDS_KEY2 && other_key) begin
							kst_r <= KDS_IDLE; // Two keys together: wait for one alone
						end else if (row_r == key_row_r && deb_r == 11'h000) begin
							kst_r <= ret_s[key_col_r] ? KDS_HELD : KDS_IDLE;
						end
					end
					KDS_HELD: begin
						if (row_r == key_row_r && !ret_s[key_col_r]) begin
							kst_r <= KDS_IDLE; // One entry per depression
						end
					end
					default: kst_r <= KDS_IDLE;
				endcase
			end
		end
	end

	// Debounce interval in internal cycles
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			deb_r <= 11'(`KDS_DEBOUNCE_TICKS);
		end else if (CE_I) begin
			if (kst_r != KDS_DEBOUNCE) begin
				deb_r <= 11'(`KDS_DEBOUNCE_TICKS);
			end else if (tick && deb_r != 11'h000) begin
				deb_r <= deb_r - 11'h001;
			end
		end
	end

	// FIFO source selection; a set error freezes entry
	assign push_req = key_ready || (mode == KDS_STROBE && stb_rise);
	assign push_data = key_ready ? {cstb_s, shift_s, key_row_r, key_col_r} : ret_s;
	assign full = cnt_r == 4'(`KDS_FIFO_DEPTH);
	assign empty = cnt_r == 4'h0;
	assign push_ok = push_req && !full && !err_r;
	assign pop_ok = rd_fifo && !empty;

	// FIFO storage, one slot per generate pass
	genvar g;
	generate
		for (g = 0; g < `KDS_FIFO_DEPTH; g++) begin : g_fifo
			always_ff @(posedge CLK_I) begin
				if (CE_I && push_ok && wptr_r == 3'(g)) begin
					fifo_mem[g] <= push_data;
				end
			end
		end
	endgenerate

	// FIFO pointers and fill count
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			wptr_r <= 3'h0;
			rptr_r <= 3'h0;
			cnt_r <= 4'h0;
		end else if (CE_I) begin
			if (clr_fifo) begin
				wptr_r <= 3'h0;
				rptr_r <= 3'h0;
				cnt_r <= 4'h0;
			end else begin
				wptr_r <= wptr_r + 3'(push_ok);
				rptr_r <= rptr_r + 3'(pop_ok);
				cnt_r <= cnt_r + 4'(push_ok) - 4'(pop_ok);
			end
		end
	end

	// Sensor image, rows written straight from return lines
	generate
		for (g = 0; g < 8; g++) begin : g_sensor
			always_ff @(posedge CLK_I or negedge RSTN_I) begin
				if (!RSTN_I) begin
					sensor_ram[g] <= 8'h00;
				end else if (CE_I && mode == KDS_SENSOR && row_end && row_r == 3'(g)) begin
					sensor_ram[g] <= ret_s;
				end
			end
		end
	endgenerate

	// Sticky flags; a set in the clearing cycle wins
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			overrun_r <= 1'b0;
			underrun_r <= 1'b0;
			err_r <= 1'b0;
			sen_chg_r <= 1'b0;
		end else if (CE_I) begin
			overrun_r <= (push_req && full) || (overrun_r && !clr_fifo);
			underrun_r <= (rd_fifo && empty) || (underrun_r && !clr_fifo);
			err_r <= multi_set || (err_r && !clr_fifo);
			sen_chg_r <= (mode == KDS_SENSOR && row_end && ret_s != sensor_ram[row_r])
				|| (sen_chg_r && !clr_fifo);
		end
	end

	// Status byte
	always_comb begin
		status = {5'h00, cnt_r[2:0]};
		status[`KDS_ST_FULL] = full;
		status[`KDS_ST_OVER] = overrun_r;
		status[`KDS_ST_UNDER] = underrun_r;
		status[`KDS_ST_SE] = (mode == KDS_SENSOR) ? sen_chg_r : err_r;
		status[`KDS_ST_BUSY] = clr_busy_r;
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			RDATA_O <= 8'h00;
		end else if (CE_I) begin
			if (!RD_I) begin
				RDATA_O <= 8'h00;
			end else if (ADDR_I[`KDS_SENSOR_SEL]) begin
				RDATA_O <= sensor_ram[ADDR_I[2:0]];
			end else if (ADDR_I == `KDS_OFS_STATUS) begin
				RDATA_O <= status;
			end else if (ADDR_I == `KDS_OFS_FIFO) begin
				RDATA_O <= empty ? 8'h00 : fifo_mem[rptr_r];
			end else if (ADDR_I == `KDS_OFS_CTRL) begin
				RDATA_O <= ctrl_r;
			end else if (ADDR_I == `KDS_OFS_DADDR) begin
				RDATA_O <= {3'h0, ai_r, daddr_r};
			end else begin
				RDATA_O <= 8'h00;
			end
		end
	end
endmodule // kds_top
`default_nettype wire

// [kds_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module kds_top_bench;
	logic clk = 1'b0;
	logic rstn, ce, wr, rd;
	logic [3:0] addr;
	logic [7:0] wdata, v;
	wire logic [7:0] rdata, ret, disp_data;
	wire logic shift, ctrl_stb, disp_blank;
	wire logic [2:0] scan;
	wire logic [3:0] digit;
	int n_mismatch = 0;
	int checks = 0;
	// Free-running 100 MHz clock
	always #5 clk = ~clk;
	kds_top u_kds_top (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .RET_I(ret), .SHIFT_I(shift), .CTRL_STB_I(ctrl_stb), .SCAN_O(scan),
		.DIGIT_O(digit), .DISP_DATA_O(disp_data), .DISP_BLANK_O(disp_blank));
	kds_far_model u_kds_far_model (.clk_i(clk), .scan_i(scan), .ret_o(ret), .shift_o(shift),
		.ctrl_stb_o(ctrl_stb));
	function automatic logic [7:0] pat(input int r);
		return 8'h3c ^ 8'(17 * r);
	endfunction
	function automatic logic [7:0] sdat(input int i);
		return 8'(8'h05 + 33 * i);
	endfunction
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Answer is sampled in the cycle after the strobe edge
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk(d, exp);
	endtask
	task automatic conclude();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog: the whole sequence needs about 72300 cycles
	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		conclude();
	end
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(4'h0, 8'h00);
		rd_chk(4'h5, 8'h00);
		rd_chk(4'h6, 8'h00);
		// Left entry, sixteen characters, auto increment, then wrap
		wr_reg(4'h2, 8'h10);
		for (int i = 0; i < 16; i++)
			wr_reg(4'h3, 8'h40 + 8'(i));
		rd_chk(4'h2, 8'h10);
		wr_reg(4'h3, 8'h77);
		rd_chk(4'h2, 8'h11);
		chk({4'h0, digit}, 8'h00);
		chk(disp_data, 8'h77);
		// Fixed address: repeated writes land in one place
		wr_reg(4'h2, 8'h00);
		wr_reg(4'h3, 8'h5a);
		wr_reg(4'h3, 8'h5b);
		rd_chk(4'h2, 8'h00);
		chk(disp_data, 8'h5b);
		// Frozen clock enable: a write in that time must not land
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(4'h2, 8'h15);
		ce <= 1'b1;
		rd_chk(4'h2, 8'h00);
		// Right entry, eight characters; nine writes push the first out
		wr_reg(4'h0, 8'h0c);
		wr_reg(4'h2, 8'h10);
		for (int i = 0; i < 9; i++)
			wr_reg(4'h3, 8'hc0 + 8'(i));
		rd_chk(4'h2, 8'h11);
		chk(disp_data, 8'hc1);
		// Strobed input: fill past full, drain past empty
		wr_reg(4'h0, 8'h03);
		rd_chk(4'h0, 8'h03);
		wr_reg(4'h1, 8'h02);
		for (int i = 0; i < 9; i++) begin
			u_kds_far_model.pulse(sdat(i));
			rd_chk(4'h5, i < 7 ? 8'(i + 1) : (i == 7 ? 8'h08 : 8'h18));
		end
		for (int i = 0; i < 8; i++)
			rd_chk(4'h4, sdat(i));
		rd_chk(4'h5, 8'h10);
		rd_chk(4'h4, 8'h00);
		rd_chk(4'h5, 8'h30);
		wr_reg(4'h1, 8'h02);
		rd_chk(4'h5, 8'h00);
		// Sensor matrix with both modifiers held, nine rows of scanning
		wr_reg(4'h0, 8'h02);
		u_kds_far_model.strobed <= 1'b0;
		u_kds_far_model.shift_o <= 1'b1;
		u_kds_far_model.ctrl_stb_o <= 1'b1;
		for (int r = 0; r < 8; r++)
			u_kds_far_model.keys[r] <= pat(r);
		repeat (72000) @(posedge clk);
		for (int r = 0; r < 8; r++)
			rd_chk(4'h8 + 4'(r), pat(r));
		rd_reg(4'h5, v);
		chk(v, 8'h40);
		// Clear in progress: busy shown, data writes refused
		wr_reg(4'h2, 8'h13);
		wr_reg(4'h1, 8'h01);
		rd_reg(4'h5, v);
		chk(v, 8'hc0);
		wr_reg(4'h3, 8'h99);
		rd_chk(4'h2, 8'h13);
		// Clear all: flags gone, busy again, rows and digits back at zero
		wr_reg(4'h1, 8'h04);
		rd_chk(4'h5, 8'h80);
		chk({5'h00, scan}, 8'h00);
		chk({4'h0, digit}, 8'h00);
		repeat (10) @(posedge clk);
		conclude();
	end
endmodule // kds_top_bench
`default_nettype wire

// [kds_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module kds_top_sva (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic CE_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [7:0] RDATA_O,
	input wire logic [2:0] SCAN_O,
	input wire logic [3:0] DIGIT_O,
	input wire logic DISP_BLANK_O
);
	int dcnt_r;
	int scnt_r;
	logic [3:0] dig_r;
	logic [2:0] scan_r;
	logic disp8_r;
	int clr_left;
	logic restart_r;
	logic clr_cmd;
	logic restart_cmd;
	// Clear commands as seen on the bus
	assign clr_cmd = CE_I && WR_I && ADDR_I == 4'h1 && (WDATA_I[0] || WDATA_I[2]);
	assign restart_cmd = CE_I && WR_I && ADDR_I == 4'h1 && WDATA_I[2];
	// Clear all restarts the chain; outputs follow one enabled edge later
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			restart_r <= 1'b0;
		end else if (CE_I) begin
			restart_r <= restart_cmd;
		end
	end
	// Digit periods a running clear may still keep the digits blank
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			clr_left <= 0;
		end else if (clr_cmd) begin
			clr_left <= disp8_r ? 8 : 16;
		end else if (DIGIT_O != dig_r && clr_left > 0 && !(restart_r && CE_I)) begin
			clr_left <= clr_left - 1;
		end
	end
	// Cycles since the digit index last moved; frozen cycles do not count
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			dcnt_r <= 0;
			dig_r <= 4'h0;
		end else if (restart_r && CE_I) begin
			dcnt_r <= 0;
			dig_r <= 4'h0;
		end else if (DIGIT_O != dig_r) begin
			dcnt_r <= 0;
			dig_r <= DIGIT_O;
		end else if (CE_I)
			dcnt_r <= dcnt_r + 1;
	end
	// Same for the key row
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			scnt_r <= 0;
			scan_r <= 3'h0;
		end else if (restart_r && CE_I) begin
			scnt_r <= 0;
			scan_r <= 3'h0;
		end else if (SCAN_O != scan_r) begin
			scnt_r <= 0;
			scan_r <= SCAN_O;
		end else if (CE_I)
			scnt_r <= scnt_r + 1;
	end
	// Shadow of the eight-character bit, needed for the digit wrap
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I)
			disp8_r <= 1'b0;
		else if (CE_I && WR_I && ADDR_I == 4'h0)
			disp8_r <= WDATA_I[2];
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	AST_RDATA_IDLE: assert property (!$past(RD_I && CE_I) |-> RDATA_O == 8'h00)
		else $error("read data not zero outside answer cycle");
	AST_UNMAPPED_RD: assert property (CE_I && RD_I && (ADDR_I == 4'h6 || ADDR_I == 4'h7 || ADDR_I == 4'h3)
		|=> RDATA_O == 8'h00)
		else $error("unmapped or write-only read not zero");
	AST_BLANK_LEAD: assert property (dcnt_r < 15990 |-> DISP_BLANK_O)
		else $error("digit lit during lead blanking");
	AST_BLANK_MIN: assert property (!DISP_BLANK_O |-> dcnt_r >= 15990)
		else $error("blanking too short");
	AST_BLANK_END: assert property (dcnt_r == 16100 && clr_left == 0 |-> !DISP_BLANK_O)
		else $error("blanking too long");
	AST_DIGIT_PERIOD: assert property (DIGIT_O != dig_r |-> dcnt_r > 63990 && dcnt_r < 64010)
		else $error("digit period wrong");
	AST_DIGIT_STEP: assert property (DIGIT_O != dig_r |-> DIGIT_O == ((dig_r + 4'h1) & (disp8_r ? 4'h7 : 4'hf)))
		else $error("digit order wrong");
	AST_SCAN_PERIOD: assert property (SCAN_O != scan_r |-> scnt_r > 7990 && scnt_r < 8010)
		else $error("row time wrong");
	AST_SCAN_STEP: assert property (SCAN_O != scan_r |-> SCAN_O == scan_r + 3'h1)
		else $error("row order wrong");
	AST_CLEAR_BLANK: assert property (CE_I && WR_I && ADDR_I == 4'h1 && WDATA_I[0] |-> ##2 DISP_BLANK_O [*8])
		else $error("display lit while clearing");
	cover property (DIGIT_O != dig_r);
	cover property (SCAN_O != scan_r);
	cover property (WR_I && ADDR_I == 4'h1 && WDATA_I[0]);
	cover property (restart_r);
endmodule // kds_top_sva
bind kds_top kds_top_sva u_kds_top_sva (.CLK_I, .RSTN_I, .CE_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
	.SCAN_O, .DIGIT_O, .DISP_BLANK_O);
`default_nettype wire
